// ### logic/bmw_cfg.svh
// Address map, field positions, reset values and timing for the misc I/O and watchdog block
`ifndef BMW_CFG_SVH
`define BMW_CFG_SVH
`define BMW_ADDR_WDOG_ENABLE   16'h01c0
`define BMW_ADDR_WDOG_STROBE   16'h01c8
`define BMW_ADDR_MISC_CONTROL  16'h01d4
`define BMW_BIT_CTS            7
`define BMW_BIT_RTS            6
`define BMW_BIT_LED            5
`define BMW_BIT_PIN_DIR        4
`define BMW_BIT_PRN_DIR        3
`define BMW_BIT_PERIPH_SEL     2
`define BMW_BIT_SHIFT_CLK      1
`define BMW_BIT_SERIAL_DATA    0
`define BMW_MISC_RESET         7'h00
`define BMW_WDOG_TIMEOUT_MS    1500
`define BMW_CLK_MHZ            100
`define BMW_WDOG_TIMEOUT_CYC   (`BMW_WDOG_TIMEOUT_MS * 1000 * `BMW_CLK_MHZ)
`endif

// ### logic/bmw_pkg.sv
// Types shared by the misc I/O and watchdog block
package bmw_pkg;
    typedef struct packed {
        logic        write_strobe;
        logic        read_strobe;
        logic [15:0] address;
        logic [7:0]  write_data;
    } bmw_io_req_type;

    typedef struct packed {
        logic rts;
        logic led;
        logic serial_pin_direction;
        logic printer_port_input_select;
        logic serial_peripheral_choice;
        logic serial_shift_clock_bit;
        logic serial_data_out;
    } bmw_misc_type;

    typedef struct packed {
        logic [1:0]  cts_sync;
        logic [1:0]  data_sync;
        bmw_misc_type misc;
        logic        wdog_enabled;
        logic [31:0] wdog_count;
        logic        wdog_reset;
        logic [7:0]  read_data;
    } bmw_state_type;
endpackage

// ### logic/bmw_misc_io.sv
// Misc control register, watchdog enable and watchdog strobe ports on the I/O bus
`timescale 1ns/100ps
`include "bmw_cfg.svh"

module bmw_misc_io #(
    parameter int unsigned WDOG_TIMEOUT_CYC = `BMW_WDOG_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Processor I/O bus
    input  wire bmw_pkg::bmw_io_req_type io_req,
    output logic [7:0]            io_read_data,
    // Board configuration
    input  wire logic             wdog_jumper_installed,
    input  wire logic             printer_sw_dir_jumper,
    // Peripheral pins
    input  wire logic             cts_pin,
    output logic                  rts_pin,
    output logic                  led_on,
    output logic                  printer_port_input_select,
    output logic                  serial_peripheral_choice,
    output logic                  serial_shift_clock_bit,
    input  wire logic             serial_data_in,
    output logic                  serial_data_out,
    output logic                  serial_data_oe,
    // Watchdog
    output logic                  wdog_cpu_reset
);
    import bmw_pkg::*;

    bmw_state_type state;
    bmw_state_type next_state;
    logic          wr_misc;
    logic          wr_enable;
    logic          wr_strobe;
    logic          rd_misc;

    // Full 16-bit compare keeps the three ports off neighbouring devices
    // misc register, watchdog enable and watchdog strobe decode
    assign wr_misc   = io_req.write_strobe && io_req.address == `BMW_ADDR_MISC_CONTROL;
    assign rd_misc   = io_req.read_strobe && io_req.address == `BMW_ADDR_MISC_CONTROL;
    assign wr_enable = io_req.write_strobe && io_req.address == `BMW_ADDR_WDOG_ENABLE;
    assign wr_strobe = io_req.write_strobe && io_req.address == `BMW_ADDR_WDOG_STROBE;

    always_comb begin
        next_state = state;
        // Two flops on CTS and the data pin; jumpers are static and read direct
        next_state.cts_sync  = {state.cts_sync[0], cts_pin};
        next_state.data_sync = {state.data_sync[0], serial_data_in};
        next_state.wdog_reset = 1'b0;
        if (wr_misc) begin
            // bit 7 write has no effect
            next_state.misc.rts = io_req.write_data[`BMW_BIT_RTS];
            next_state.misc.led = io_req.write_data[`BMW_BIT_LED];
            next_state.misc.serial_pin_direction = io_req.write_data[`BMW_BIT_PIN_DIR];
            next_state.misc.printer_port_input_select = io_req.write_data[`BMW_BIT_PRN_DIR];
            next_state.misc.serial_peripheral_choice = io_req.write_data[`BMW_BIT_PERIPH_SEL];
            next_state.misc.serial_shift_clock_bit = io_req.write_data[`BMW_BIT_SHIFT_CLK];
            next_state.misc.serial_data_out = io_req.write_data[`BMW_BIT_SERIAL_DATA];
        end
        // Read data is registered; other ports read as zero
        next_state.read_data = 8'h00;
        if (rd_misc) begin
            next_state.read_data[`BMW_BIT_CTS] = state.cts_sync[1];
            next_state.read_data[6:1] = {state.misc.rts, state.misc.led,
                state.misc.serial_pin_direction, state.misc.printer_port_input_select,
                state.misc.serial_peripheral_choice, state.misc.serial_shift_clock_bit};
            // data bit reads pin when released
            next_state.read_data[`BMW_BIT_SERIAL_DATA] = state.misc.serial_pin_direction ?
                state.data_sync[1] : state.misc.serial_data_out;
        end
        if (state.wdog_enabled) begin
            if (wr_strobe) begin
                next_state.wdog_count = 32'h0;
            end else if (state.wdog_count >= WDOG_TIMEOUT_CYC - 1) begin
                next_state.wdog_reset = 1'b1;
                next_state.wdog_count = 32'h0;
            end else begin
                next_state.wdog_count = state.wdog_count + 32'h1;
            end
        end
        // Enable port wins over counting so a rewrite always restarts the interval
        // start only with jumper present
        if (wr_enable) begin
            next_state.wdog_enabled = io_req.write_data[0] && wdog_jumper_installed;
            next_state.wdog_count = 32'h0;
        end
        // disabled watchdog never fires
        // A timeout that meets an enable restart still fires; a stop or a strobe suppresses it
        if (!next_state.wdog_enabled) begin
            next_state.wdog_reset = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        // Clock enable freezes synchronisers and count alike
        // reset clears everything
        if (rst) begin
            state <= '0;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign io_read_data    = state.read_data;
    assign rts_pin         = state.misc.rts;
    assign led_on          = state.misc.led;
    assign printer_port_input_select = printer_sw_dir_jumper &&
        state.misc.printer_port_input_select;
    assign serial_peripheral_choice = state.misc.serial_peripheral_choice;
    assign serial_shift_clock_bit = state.misc.serial_shift_clock_bit;
    // drive pin only while bit 4 is zero
    assign serial_data_out = state.misc.serial_data_out;
    // Released pin lets the peripheral drive returned data
    assign serial_data_oe  = !state.misc.serial_pin_direction;
    assign wdog_cpu_reset  = state.wdog_reset;

    // Assertions
    a_led_follows_write: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> led_on == $past(io_req.write_data[5]))
        else $error("LED does not follow write");
    a_rts_follows_write: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> rts_pin == $past(io_req.write_data[6]))
        else $error("RTS does not follow write");
    a_pin_dir_oe: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> serial_data_oe == !$past(io_req.write_data[4]))
        else $error("Serial pin enable wrong");
    a_prn_dir_jumper: assert property (@(posedge core_clk) disable iff (rst)
        !printer_sw_dir_jumper |-> !printer_port_input_select)
        else $error("Printer input without jumper");
    a_sel_follows: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> serial_peripheral_choice == $past(io_req.write_data[2]))
        else $error("Peripheral select wrong");
    a_clk_follows: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> serial_shift_clock_bit == $past(io_req.write_data[1]))
        else $error("Shift clock wrong");
    a_read_led: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && rd_misc |=> io_read_data[5] == $past(state.misc.led))
        else $error("Readback of LED wrong");
    a_cts_read: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && rd_misc |=> io_read_data[7] == $past(state.cts_sync[1]))
        else $error("CTS readback wrong");
    a_data_read: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && rd_misc && !state.misc.serial_pin_direction
        |=> io_read_data[0] == $past(state.misc.serial_data_out))
        else $error("Data readback wrong");
    a_wdog_start: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_enable && io_req.write_data[0] |=> state.wdog_enabled ==
        $past(wdog_jumper_installed))
        else $error("Watchdog start wrong");
    a_wdog_stop: assert property (@(posedge core_clk) disable iff (rst)
        !state.wdog_enabled |=> !wdog_cpu_reset)
        else $error("Reset while disabled");
    a_strobe_clear: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && state.wdog_enabled && wr_strobe && !wr_enable |=> state.wdog_count == 32'h0)
        else $error("Strobe did not restart");
    a_timeout_fire: assert property (@(posedge core_clk) disable iff (rst)
        $past(clk_en) && wdog_cpu_reset |-> $past(state.wdog_count) >= WDOG_TIMEOUT_CYC - 1)
        else $error("Reset before interval");
    a_reset_clear: assert property (@(posedge core_clk)
        rst |=> !led_on && !state.wdog_enabled && !printer_port_input_select)
        else $error("Reset state wrong");

    a_prn_dir_write: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> printer_port_input_select ==
        ($past(io_req.write_data[3]) && printer_sw_dir_jumper))
        else $error("Printer direction wrong");
    a_data_out_follows: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_misc |=> serial_data_out == $past(io_req.write_data[0]))
        else $error("Data out wrong");
    a_data_pin_read: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && rd_misc && state.misc.serial_pin_direction
        |=> io_read_data[0] == $past(state.data_sync[1]))
        else $error("Pin readback wrong");
    a_unmapped_read: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && io_req.read_strobe && !rd_misc |=> io_read_data == 8'h00)
        else $error("Unmapped read not zero");

    // Enable rewrite restarts the interval even while running
    a_enable_restart: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_enable |=> state.wdog_count == 32'h0)
        else $error("Enable did not restart");
    a_freeze_state: assert property (@(posedge core_clk) disable iff (rst)
        !clk_en |=> $stable(state))
        else $error("State moved while frozen");

    c_wdog_fire: cover property (@(posedge core_clk) wdog_cpu_reset);
    c_misc_write: cover property (@(posedge core_clk) clk_en && wr_misc);
    c_strobe: cover property (@(posedge core_clk) clk_en && wr_strobe && state.wdog_enabled);
    c_count_frozen: cover property (@(posedge core_clk) !clk_en && state.wdog_enabled);
    c_pin_read: cover property (@(posedge core_clk) clk_en && rd_misc && state.misc.serial_pin_direction);
endmodule

// ### testbench/bmw_host_model.sv
// Host processor model issuing cycles on the board I/O bus
`timescale 1ns/100ps
module bmw_host_model (
    // Bus
    input  wire logic                    core_clk,
    output bmw_pkg::bmw_io_req_type      io_req,
    input  wire logic [7:0]              io_read_data
);
    import bmw_pkg::*;
    initial io_req = '0;
    // One strobed cycle; after it the address and data lines show inverted junk
    task automatic io_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d,
                            output logic [7:0] q);
        @(posedge core_clk);
        #1;
        io_req = '{write_strobe: wr, read_strobe: !wr, address: a, write_data: d};
        @(posedge core_clk);
        #1;
        q = io_read_data;
        io_req = '{write_strobe: 1'b0, read_strobe: 1'b0, address: ~a, write_data: ~d};
    endtask
    // read, change one bit, write back
    // host writes and samples the data bit like any other
    task automatic rmw(input int b, input logic v);
        logic [7:0] q;
        io_cycle(1'b0, 16'h01d4, 8'h00, q);
        q[b] = v;
        io_cycle(1'b1, 16'h01d4, q, q);
    endtask
endmodule

// ### testbench/tb.sv
// Self-checking testbench for the misc I/O and watchdog block
`timescale 1ns/100ps
module tb;
    import bmw_pkg::*;
    typedef struct packed {logic [7:0] wd; logic [7:0] rd; logic [6:0] pins;} bmw_row_type;
    bmw_row_type     rows [6] = '{'{8'hff, 8'h7f, 7'h6f}, '{8'h00, 8'h00, 7'h10},
        '{8'h55, 8'h55, 7'h45}, '{8'h2a, 8'h2a, 7'h3a}, '{8'h10, 8'h11, 7'h00},
        '{8'h81, 8'h01, 7'h11}};
    logic            core_clk = 0, rst = 1, wdj = 1, pj = 1, cts_pin = 0, sdin = 1, ce = 1;
    logic            rts_pin, led_on, prn_in, sel, sclk, sdout, sdoe, wdog_cpu_reset;
    logic [7:0]      io_read_data, q;
    logic [6:0]      pins;
    bmw_io_req_type  io_req;
    int              fails = 0, n_compared = 0, cyc = 0, c;
    assign pins = {rts_pin, led_on, sdoe, prn_in, sel, sclk, sdout};
    bmw_misc_io #(.WDOG_TIMEOUT_CYC(20)) u_bmw_misc_io (.core_clk(core_clk), .rst(rst),
        .clk_en(ce), .io_req(io_req), .io_read_data(io_read_data),
        .wdog_jumper_installed(wdj), .printer_sw_dir_jumper(pj), .cts_pin(cts_pin),
        .rts_pin(rts_pin), .led_on(led_on), .printer_port_input_select(prn_in),
        .serial_peripheral_choice(sel), .serial_shift_clock_bit(sclk),
        .serial_data_in(sdin), .serial_data_out(sdout), .serial_data_oe(sdoe),
        .wdog_cpu_reset(wdog_cpu_reset));
    bmw_host_model u_bmw_host_model (.core_clk(core_clk), .io_req(io_req),
        .io_read_data(io_read_data));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %0t %s", $time, m);
            fails++;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_bmw_host_model.io_cycle(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a);
        u_bmw_host_model.io_cycle(1'b0, a, 8'h00, q);
    endtask
    // Cycles until the watchdog pulse, n+1 when none came
    task automatic wait_pulse(input int n);
        for (c = 1; c <= n; c++) begin
            @(posedge core_clk);
            #1;
            if (wdog_cpu_reset === 1'b1) break;
        end
    endtask
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst = 0;
        chk({1'b0, pins}, 8'h10, "reset pins");
        rd(16'h01d4);
        chk(q, 8'h00, "reset read");
        foreach (rows[i]) begin
            wr(16'h01d4, rows[i].wd);
            chk({1'b0, pins}, {1'b0, rows[i].pins}, "pins");
            rd(16'h01d4);
            chk(q, rows[i].rd, "readback");
        end
        cts_pin = 1;
        repeat (3) @(posedge core_clk);
        rd(16'h01d4);
        chk(q, 8'h81, "cts read");
        u_bmw_host_model.rmw(5, 1'b1);
        rd(16'h01d4);
        chk(q, 8'ha1, "rmw led");
        wr(16'h01d4, 8'h08);
        pj = 0;
        #1 chk({7'h00, prn_in}, 8'h00, "printer jumper off");
        pj = 1;
        rd(16'h01d8);
        chk(q, 8'h00, "unmapped read");
        rd(16'h01c0);
        chk(q, 8'h00, "enable port read");
        wr(16'h01c0, 8'hff);
        wait_pulse(40);
        chk(8'(c), 8'd20, "timeout");
        wr(16'h01c0, 8'h01);
        wait_pulse(12);
        wr(16'h01c8, 8'h5a);
        wait_pulse(14);
        chk(8'(c), 8'd15, "strobe restart");
        wait_pulse(10);
        chk(8'(c), 8'd6, "after strobe");
        wr(16'h01c0, 8'hfe);
        wait_pulse(40);
        chk(8'(c), 8'd41, "disabled");
        wdj = 0;
        wr(16'h01c0, 8'h01);
        wait_pulse(40);
        chk(8'(c), 8'd41, "no jumper");
        wdj = 1;
        wr(16'h01c0, 8'h01);
        ce = 0;
        wait_pulse(10);
        chk(8'(c), 8'd11, "frozen count");
        ce = 1;
        wait_pulse(30);
        chk(8'(c), 8'd20, "resumed count");
        wr(16'h01c0, 8'h01);
        rst = 1;
        repeat (2) @(posedge core_clk);
        #1 rst = 0;
        chk({1'b0, pins}, 8'h10, "second reset pins");
        wait_pulse(40);
        chk(8'(c), 8'd41, "reset disables");
        close_out();
    end
endmodule
